// ===== csb_defines.svh
// register indexes, field positions, reset values and timing counts of the clocked serial block
`ifndef CSB_DEFINES_SVH
`define CSB_DEFINES_SVH
`define CSB_IDX_CTRL1 32'hFFFFF240
`define CSB_IDX_DATA 32'hFFFFF241
`define CSB_IDX_MODE 32'hFFFFF243
`define CSB_IDX_BAUD0 32'hFFFFF244
`define CSB_IDX_BAUD1 32'hFFFFF245
`define CSB_IDX_IRQ_STAT 32'hFFFFF248
`define CSB_IDX_IRQ_MASK 32'hFFFFF249
`define CSB_CTRL1_START 7
`define CSB_CTRL1_ABORT 6
`define CSB_CTRL1_TMODE_LSB 4
`define CSB_CTRL1_RATE_LSB 0
`define CSB_MODE_OP_LSB 2
`define CSB_STAT_ACTIVE 3
`define CSB_STAT_SHIFT 2
`define CSB_BAUD0_IDLE 6
`define CSB_BAUD1_GATE 7
`define CSB_IRQ_TX_EMPTY 0
`define CSB_IRQ_RX_FULL 1
`define CSB_CTRL1_RST 8'h01
`define CSB_RATE_EXT 3'h7
`define CSB_TICK_DIV 4
`define CSB_EXP_BASE 3
`define CSB_BITS 4'h8
`endif

// ===== csb_pkg.sv
// types shared by the clocked serial block
package csb_pkg;
   typedef enum logic [1:0] {
      CSB_OP_PORT = 2'b00,
      CSB_OP_SIO = 2'b01,
      CSB_OP_BUS2W = 2'b10,
      CSB_OP_RSVD = 2'b11
   } csb_op_t;
   typedef enum logic [1:0] {
      CSB_TM_TX = 2'b00,
      CSB_TM_RSVD = 2'b01,
      CSB_TM_TXRX = 2'b10,
      CSB_TM_RX = 2'b11
   } csb_tmode_t;
   typedef enum logic [1:0] {
      CSB_ST_IDLE = 2'b00,
      CSB_ST_WAIT = 2'b01,
      CSB_ST_SHIFT = 2'b10
   } csb_state_t;
endpackage

// ===== csb_clkdiv.sv
// serial clock source: internal divider of the prescaled tick or external clock edges
`timescale 1ns/1ps
`default_nettype none
`include "csb_defines.svh"
module csb_clkdiv #(
   parameter int CNT_W = 12
) (
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic run_i,
   input wire logic ext_i,
   input wire logic sck_ext_i,
   input wire logic [2:0] exp_i,
   output logic sck_o,
   output logic fall_o,
   output logic rise_o
);
   // one serial period is TICK_DIV * 2^(n) clocks, so a half period is 2^(n+1) clocks
   logic [CNT_W-1:0] cnt_q;
   logic [CNT_W-1:0] cnt_d;
   logic sck_q;
   logic sck_d;
   logic ext_prev_q;
   logic [3:0] n_exp;
   logic [CNT_W-1:0] half_last;
   logic int_toggle;

   assign n_exp = 4'(exp_i) + 4'(`CSB_EXP_BASE);
   assign half_last = CNT_W'((`CSB_TICK_DIV / 2) << n_exp) - CNT_W'(1);
   assign int_toggle = run_i && !ext_i && (cnt_q == half_last);
   assign cnt_d = (!run_i || int_toggle) ? '0 : cnt_q + CNT_W'(1);
   // clock idles high so the first edge of a transfer is a falling one
   assign sck_d = !run_i ? 1'b1 : (int_toggle ? !sck_q : sck_q);

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         cnt_q <= '0;
         sck_q <= 1'b1;
         ext_prev_q <= 1'b1;
      end else begin
         cnt_q <= cnt_d;
         sck_q <= sck_d;
         ext_prev_q <= sck_ext_i;
      end
   end

   assign sck_o = sck_q;
   assign fall_o = ext_i ? (run_i && ext_prev_q && !sck_ext_i) : (int_toggle && sck_q);
   assign rise_o = ext_i ? (run_i && !ext_prev_q && sck_ext_i) : (int_toggle && !sck_q);
endmodule
`default_nettype wire

// ===== csb_regs.sv
// clocked 8-bit serial interface: AXI4-Lite registers, shift engine and interrupt
// Summary of operation
// R1: op field selects port, serial, two-wire mode
// R2: start bit one begins, zero stops transfers
// R3: abort bit one aborts current transfer
// R4: transfer mode selects transmit, both, receive
// R5: rate code picks exponent or external clock
// R6: serial clock equals tick over two-power-n
// R7: software stops and aborts before changing modes
// R8: data buffer reads receive, writes transmit
// R9: clock gate bit switches internal clock
// R10: software writes zero to baud bit zero
// R11: transfer active until last bit shifted
// R12: transmit shifts out least significant first
// R13: buffer load to shifter raises empty interrupt
// R14: abort stops at once, clears active flag
// R15: engine runs only in serial mode
// R16: shift flag high while bits shift
`timescale 1ns/1ps
`default_nettype none
`include "csb_defines.svh"
module csb_regs #(
   parameter int ADDR_W = 14
) (
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic sck_ext_i,
   input wire logic si_i,
   output logic sck_o,
   output logic sck_oe_n_o,
   output logic so_o,
   output logic idle_run_enable_o,
   output logic irq_o
);
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   localparam int IW = ADDR_W - 2;

   function automatic logic idx_hit(input logic [ADDR_W-1:0] addr, input logic [31:0] idx);
      idx_hit = (addr[ADDR_W-1:2] == idx[IW-1:0]);
   endfunction

   // ---------------- bus slave: write path ----------------
   logic aw_held_q;
   logic w_held_q;
   logic [ADDR_W-1:0] awaddr_q;
   logic [7:0] wbyte_q;
   logic wlane_q;
   logic bvalid_q;
   logic [1:0] bresp_q;
   logic wr_fire;
   logic wr_lane;

   assign s_axi_awready = !aw_held_q && !bvalid_q;
   assign s_axi_wready = !w_held_q && !bvalid_q;
   assign wr_fire = aw_held_q && w_held_q && !bvalid_q;
   assign wr_lane = wr_fire && wlane_q;

   logic wr_ctrl1;
   logic wr_data;
   logic wr_mode;
   logic wr_baud0;
   logic wr_baud1;
   logic wr_istat;
   logic wr_imask;
   logic wr_mapped;
   assign wr_ctrl1 = wr_lane && idx_hit(awaddr_q, `CSB_IDX_CTRL1);
   assign wr_data = wr_lane && idx_hit(awaddr_q, `CSB_IDX_DATA);
   assign wr_mode = wr_lane && idx_hit(awaddr_q, `CSB_IDX_MODE);
   assign wr_baud0 = wr_lane && idx_hit(awaddr_q, `CSB_IDX_BAUD0);
   assign wr_baud1 = wr_lane && idx_hit(awaddr_q, `CSB_IDX_BAUD1);
   assign wr_istat = wr_lane && idx_hit(awaddr_q, `CSB_IDX_IRQ_STAT);
   assign wr_imask = wr_lane && idx_hit(awaddr_q, `CSB_IDX_IRQ_MASK);
   assign wr_mapped = idx_hit(awaddr_q, `CSB_IDX_CTRL1) || idx_hit(awaddr_q, `CSB_IDX_DATA)
      || idx_hit(awaddr_q, `CSB_IDX_MODE) || idx_hit(awaddr_q, `CSB_IDX_BAUD0)
      || idx_hit(awaddr_q, `CSB_IDX_BAUD1) || idx_hit(awaddr_q, `CSB_IDX_IRQ_STAT)
      || idx_hit(awaddr_q, `CSB_IDX_IRQ_MASK);

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         aw_held_q <= 1'b0;
         w_held_q <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q <= RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_q <= 1'b1;
         end else if (wr_fire) begin
            aw_held_q <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_q <= 1'b1;
         end else if (wr_fire) begin
            w_held_q <= 1'b0;
         end
         if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (s_axi_awvalid && s_axi_awready) begin
         awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         wbyte_q <= s_axi_wdata[7:0];
         wlane_q <= s_axi_wstrb[0];
      end
   end

   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;

   // ---------------- control registers ----------------
   logic start_q;
   logic abort_q;
   logic [1:0] tmode_q;
   logic [2:0] rate_q;
   logic [1:0] op_q;
   logic idle_q;
   logic gate_q;
   logic [1:0] imask_q;

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         start_q <= 1'(`CSB_CTRL1_RST >> `CSB_CTRL1_START);
         abort_q <= 1'b0;
         tmode_q <= 2'h0;
         rate_q <= 3'(`CSB_CTRL1_RST);
         op_q <= csb_pkg::CSB_OP_PORT;
         idle_q <= 1'b0;
         gate_q <= 1'b0;
         imask_q <= 2'h0;
      end else begin
         if (wr_ctrl1) begin
            start_q <= wbyte_q[`CSB_CTRL1_START]; // R2
            abort_q <= wbyte_q[`CSB_CTRL1_ABORT]; // R3
            tmode_q <= wbyte_q[`CSB_CTRL1_TMODE_LSB +: 2]; // R4
            rate_q <= wbyte_q[`CSB_CTRL1_RATE_LSB +: 3]; // R5
         end
         if (wr_mode) begin
            op_q <= wbyte_q[`CSB_MODE_OP_LSB +: 2]; // R1
         end
         if (wr_baud0) begin
            // bit 0 is write-only and carries no function
            idle_q <= wbyte_q[`CSB_BAUD0_IDLE];
         end
         if (wr_baud1) begin
            gate_q <= wbyte_q[`CSB_BAUD1_GATE]; // R9
         end
         if (wr_imask) begin
            imask_q <= wbyte_q[1:0];
         end
      end
   end

   // ---------------- serial engine ----------------
   csb_pkg::csb_state_t st_q;
   csb_pkg::csb_state_t st_d;
   logic [7:0] tx_buf_q;
   logic tx_full_q;
   logic [7:0] rx_buf_q;
   logic rx_full_q;
   logic [7:0] sh_q;
   logic [3:0] bit_cnt_q;
   logic so_q;
   logic [1:0] istat_q;

   logic sio_en;
   logic ext_clk;
   logic tm_tx;
   logic tm_rx;
   logic tm_ok;
   logic need_ok;
   logic go;
   logic div_run;
   logic sck_int;
   logic sck_fall;
   logic sck_rise;
   logic last_bit;
   logic rd_data;
   logic ev_tx_empty;
   logic ev_rx_full;

   assign sio_en = (op_q == csb_pkg::CSB_OP_SIO); // R15
   assign ext_clk = (rate_q == `CSB_RATE_EXT); // R5
   assign tm_tx = (tmode_q == csb_pkg::CSB_TM_TX) || (tmode_q == csb_pkg::CSB_TM_TXRX); // R4
   assign tm_rx = (tmode_q == csb_pkg::CSB_TM_RX) || (tmode_q == csb_pkg::CSB_TM_TXRX); // R4
   // the reserved transfer mode keeps an idle engine from leaving idle
   assign tm_ok = (tmode_q != csb_pkg::CSB_TM_RSVD);
   // transmit needs a loaded buffer, receive needs the last byte collected
   assign need_ok = (!tm_tx || tx_full_q) && (!tm_rx || !rx_full_q);
   assign go = (st_q == csb_pkg::CSB_ST_WAIT) && start_q && need_ok;
   // internal clock stops while waiting, so a slow handler inserts a wait instead of losing bits
   assign div_run = (st_q == csb_pkg::CSB_ST_SHIFT) && (ext_clk || gate_q); // R9
   assign last_bit = sck_rise && (bit_cnt_q == `CSB_BITS - 4'h1);
   assign ev_tx_empty = go && tm_tx; // R13
   assign ev_rx_full = last_bit && tm_rx && (st_q == csb_pkg::CSB_ST_SHIFT);

   csb_clkdiv #(
      .CNT_W(12)
   ) u_clkdiv (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .run_i(div_run),
      .ext_i(ext_clk),
      .sck_ext_i(sck_ext_i),
      .exp_i(rate_q),
      .sck_o(sck_int),
      .fall_o(sck_fall),
      .rise_o(sck_rise)
   ); // R6

   always_comb begin
      st_d = st_q;
      case (st_q)
         csb_pkg::CSB_ST_IDLE: begin
            if (start_q && sio_en && tm_ok) begin
               st_d = csb_pkg::CSB_ST_WAIT; // R2
            end
         end
         csb_pkg::CSB_ST_WAIT: begin
            if (!start_q) begin
               st_d = csb_pkg::CSB_ST_IDLE; // R2
            end else if (go) begin
               st_d = csb_pkg::CSB_ST_SHIFT;
            end
         end
         csb_pkg::CSB_ST_SHIFT: begin
            // a cleared start bit still lets the current byte finish
            if (last_bit) begin
               st_d = start_q ? csb_pkg::CSB_ST_WAIT : csb_pkg::CSB_ST_IDLE; // R11
            end
         end
         default: begin
            st_d = csb_pkg::CSB_ST_IDLE;
         end
      endcase
      if (abort_q || !sio_en) begin
         st_d = csb_pkg::CSB_ST_IDLE; // R14 R15
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         st_q <= csb_pkg::CSB_ST_IDLE;
         bit_cnt_q <= 4'h0;
         so_q <= 1'b1;
      end else begin
         st_q <= st_d;
         if (go) begin
            bit_cnt_q <= 4'h0;
         end else if (sck_rise && st_q == csb_pkg::CSB_ST_SHIFT) begin
            bit_cnt_q <= bit_cnt_q + 4'h1;
         end
         // between start and the first falling edge the pin keeps the last bit sent
         if (sck_fall && st_q == csb_pkg::CSB_ST_SHIFT && tm_tx) begin
            so_q <= sh_q[0]; // R12
         end
      end
   end

   // shifter: out on the falling edge, in on the rising edge, LSB first
   always_ff @(posedge sys_clk_i) begin
      if (go) begin
         sh_q <= tx_buf_q; // R13
      end else if (sck_rise && st_q == csb_pkg::CSB_ST_SHIFT) begin
         sh_q <= {si_i, sh_q[7:1]}; // R12
      end
   end

   // data buffers hold no reset value
   always_ff @(posedge sys_clk_i) begin
      if (wr_data) begin
         tx_buf_q <= wbyte_q; // R8
      end
      if (ev_rx_full) begin
         rx_buf_q <= {si_i, sh_q[7:1]}; // R8
      end
   end

   assign rd_data = s_axi_arvalid && s_axi_arready && idx_hit(s_axi_araddr, `CSB_IDX_DATA);

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         tx_full_q <= 1'b0;
         rx_full_q <= 1'b0;
         istat_q <= 2'h0;
      end else begin
         if (wr_data) begin
            tx_full_q <= 1'b1;
         end else if (ev_tx_empty) begin
            tx_full_q <= 1'b0; // R13
         end
         if (ev_rx_full) begin
            rx_full_q <= 1'b1;
         end else if (rd_data) begin
            rx_full_q <= 1'b0;
         end
         // a new event wins over a clear in the same cycle
         istat_q[`CSB_IRQ_TX_EMPTY] <= ev_tx_empty
            || (istat_q[`CSB_IRQ_TX_EMPTY] && !(wr_istat && wbyte_q[`CSB_IRQ_TX_EMPTY])); // R13
         istat_q[`CSB_IRQ_RX_FULL] <= ev_rx_full
            || (istat_q[`CSB_IRQ_RX_FULL] && !(wr_istat && wbyte_q[`CSB_IRQ_RX_FULL]));
      end
   end

   logic active_flag;
   logic shift_flag;
   assign active_flag = (st_q != csb_pkg::CSB_ST_IDLE); // R11 R14
   assign shift_flag = (st_q == csb_pkg::CSB_ST_SHIFT); // R16

   // ---------------- bus slave: read path ----------------
   logic rvalid_q;
   logic [7:0] rbyte_q;
   logic [1:0] rresp_q;
   logic [7:0] rd_mux;
   logic rd_mapped;

   assign s_axi_arready = !rvalid_q;
   assign rd_mapped = idx_hit(s_axi_araddr, `CSB_IDX_CTRL1) || idx_hit(s_axi_araddr, `CSB_IDX_DATA)
      || idx_hit(s_axi_araddr, `CSB_IDX_MODE) || idx_hit(s_axi_araddr, `CSB_IDX_BAUD0)
      || idx_hit(s_axi_araddr, `CSB_IDX_BAUD1) || idx_hit(s_axi_araddr, `CSB_IDX_IRQ_STAT)
      || idx_hit(s_axi_araddr, `CSB_IDX_IRQ_MASK);
   // the mode index reads back the status byte; start and abort read back as written
   assign rd_mux =
      idx_hit(s_axi_araddr, `CSB_IDX_CTRL1) ? {start_q, abort_q, tmode_q, 1'b0, rate_q} :
      idx_hit(s_axi_araddr, `CSB_IDX_DATA) ? rx_buf_q :
      idx_hit(s_axi_araddr, `CSB_IDX_MODE) ? {4'h0, active_flag, shift_flag, 2'h0} :
      idx_hit(s_axi_araddr, `CSB_IDX_BAUD0) ? {1'b0, idle_q, 6'h00} :
      idx_hit(s_axi_araddr, `CSB_IDX_BAUD1) ? {gate_q, 7'h00} :
      idx_hit(s_axi_araddr, `CSB_IDX_IRQ_STAT) ? {6'h00, istat_q} :
      idx_hit(s_axi_araddr, `CSB_IDX_IRQ_MASK) ? {6'h00, imask_q} : 8'h00;

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         rvalid_q <= 1'b0;
         rbyte_q <= 8'h00;
         rresp_q <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rvalid_q <= 1'b1;
         rbyte_q <= rd_mux;
         rresp_q <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end

   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = {24'h000000, rbyte_q};
   assign s_axi_rresp = rresp_q;

   // ---------------- pins and interrupt ----------------
   // the clock pin is driven only with the internal clock in serial mode
   assign sck_o = sck_int;
   assign sck_oe_n_o = !(sio_en && !ext_clk);
   assign so_o = so_q;
   assign idle_run_enable_o = idle_q;
   assign irq_o = |(istat_q & imask_q);
endmodule
`default_nettype wire

// ===== csb_regs_asserts.sv
// port-level assertions of the clocked serial block
`timescale 1ns/1ps
`default_nettype none
module csb_regs_asserts (
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic sck_o,
   input wire logic sck_oe_n_o,
   input wire logic so_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);
   logic [11:0] hi_q;
   // saturates so a long idle high phase cannot wrap to a small count
   always_ff @(posedge sys_clk_i) begin
      if (rst_i || !sck_o) hi_q <= 12'h000;
      else if (hi_q != 12'hFFF) hi_q <= hi_q + 12'h001;
   end
   wr_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write taken early");
   wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
      else $error("no write response");
   b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("write response dropped");
   rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("no read response");
   r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data not held");
   byte_lane_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000) else $error("upper bits set");
   sck_drive_a: assert property ($fell(sck_o) |-> !sck_oe_n_o) else $error("clock moved while released");
   half_min_a: assert property ($fell(sck_o) |-> hi_q >= 12'h010) else $error("clock high phase short");
   so_steady_a: assert property (!sck_oe_n_o && sck_o && $past(sck_o) |-> $stable(so_o))
      else $error("data out moved in high phase");
endmodule
bind csb_regs csb_regs_asserts i_csb_regs_asserts (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .sck_o(sck_o), .sck_oe_n_o(sck_oe_n_o), .so_o(so_o));
`default_nettype wire

// ===== csb_peer.sv
// serial peer: sends a byte to the block and captures what the block sends
`timescale 1ns/1ps
`default_nettype none
module csb_peer (
   input wire logic sck_i,
   input wire logic sel_n_i,
   input wire logic so_i,
   input wire logic [7:0] tx_i,
   output logic si_o,
   output logic [7:0] rx_o,
   output int cnt_o
);
   logic [2:0] idx = 3'h0;
   initial begin
      si_o = 1'b0;
      rx_o = 8'h00;
      cnt_o = 0;
   end
   // new bit on the fall so it is steady over the sampling rise
   always @(negedge sck_i) begin
      if (!sel_n_i) si_o <= tx_i[idx];
   end
   always @(posedge sck_i) begin
      if (!sel_n_i) begin
         rx_o <= {so_i, rx_o[7:1]};
         idx <= idx + 3'h1;
         cnt_o <= cnt_o + 1;
      end
   end
   // a released line must not keep showing the last bit
   always @(posedge sel_n_i) si_o <= ~si_o;
endmodule
`default_nettype wire

// ===== csb_regs_tb_top.sv
// self-checking bench of the clocked serial block with a serial peer
`timescale 1ns/1ps
`default_nettype none
`include "csb_defines.svh"
module csb_regs_tb_top;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
   logic [13:0] awa = 14'h0000, ara = 14'h0000;
   logic [31:0] wd = 32'h00000000;
   logic [7:0] ptx = 8'h00;
   logic xck = 1'b1;
   logic awr, wr_r, bv, arr, rv, si, sck, oen, so, idle, irq;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic [7:0] prx;
   int pcnt;
   int mismatches = 0;
   int cmp_count = 0;
   logic [31:0] seed = 32'hABFB48B9;
   logic [33:0] rq[$];
   logic [1:0] wq[$];
   always #5 clk = ~clk;
   csb_regs i_csb_regs (.sys_clk_i(clk), .rst_i(rst), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
      .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr_r),
      .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_araddr(ara), .s_axi_arvalid(arv),
      .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rre),
      .sck_ext_i(xck), .si_i(si), .sck_o(sck), .sck_oe_n_o(oen), .so_o(so), .idle_run_enable_o(idle), .irq_o(irq));
   csb_peer i_csb_peer (.sck_i(sck), .sel_n_i(oen), .so_i(so), .tx_i(ptx), .si_o(si), .rx_o(prx), .cnt_o(pcnt));
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      xs = x ^ (x << 5);
   endfunction
   // printed offsets are word indexes, so the byte address is four times the index
   function automatic logic [13:0] ba(input logic [31:0] i);
      ba = {i[11:0], 2'b00};
   endfunction
   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [33:0] got, input logic [33:0] exp, input string m);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED %0t %s", $time, m);
      end
   endtask
   task automatic tmo;
      mismatches++;
      $display("CHECK FAILED %0t wait ran out", $time);
      print_verdict();
   endtask
   task automatic bus(input logic w, input logic [31:0] i, input logic [7:0] d, input logic [1:0] e);
      int n;
      logic ta, tw, tq, tr;
      logic [1:0] dly;
      if (w) wq.push_back(e);
      else rq.push_back({e, 24'h000000, d});
      @(posedge clk);
      awa <= ba(i);
      ara <= ba(i);
      wd <= {24'h000000, d};
      awv <= w;
      wv <= w;
      arv <= !w;
      // ready comes late at random so a response must wait for it
      seed = xs(seed);
      dly = seed[1:0];
      n = 0;
      tr = 1'b0;
      while (!tr) begin
         @(negedge clk);
         ta = awv && awr;
         tw = wv && wr_r;
         tq = arv && arr;
         tr = (bv && bre) || (rv && rre);
         @(posedge clk);
         if (n == dly) begin
            bre <= w;
            rre <= !w;
         end
         if (ta) awv <= 1'b0;
         if (tw) wv <= 1'b0;
         if (tq) arv <= 1'b0;
         if (tr) bre <= 1'b0;
         if (tr) rre <= 1'b0;
         n++;
         if (n > 50) tmo();
      end
   endtask
   always @(negedge clk) begin
      if (rv === 1'b1 && rre === 1'b1) chk({rresp, rdata}, rq.pop_front(), "read result");
      if (bv === 1'b1 && bre === 1'b1) chk(bresp, wq.pop_front(), "write response");
   end
   task automatic half(output int c);
      c = 0;
      while (sck !== 1'b0) begin
         @(negedge clk);
         c++;
         if (c > 5000) tmo();
      end
      c = 0;
      while (sck === 1'b0) begin
         @(negedge clk);
         c++;
         if (c > 5000) tmo();
      end
   endtask
   initial begin
      int h;
      int n;
      logic [7:0] t;
      logic [7:0] x;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      bus(1'b0, `CSB_IDX_CTRL1, 8'h01, 2'b00);
      bus(1'b0, `CSB_IDX_MODE, 8'h00, 2'b00);
      bus(1'b0, `CSB_IDX_BAUD0, 8'h00, 2'b00);
      bus(1'b0, `CSB_IDX_BAUD1, 8'h00, 2'b00);
      bus(1'b0, `CSB_IDX_IRQ_STAT, 8'h00, 2'b00);
      bus(1'b0, 32'hFFFFF24F, 8'h00, 2'b10);
      bus(1'b1, 32'hFFFFF24F, 8'hFF, 2'b10);
      $display("test reset done");
      seed = xs(seed);
      t = seed[7:0];
      ptx = seed[15:8];
      bus(1'b1, `CSB_IDX_CTRL1, 8'h60, 2'b00);
      bus(1'b1, `CSB_IDX_MODE, 8'h04, 2'b00);
      bus(1'b1, `CSB_IDX_BAUD1, 8'h80, 2'b00);
      bus(1'b1, `CSB_IDX_BAUD0, 8'h40, 2'b00);
      chk(idle, 1'b1, "idle run bit");
      bus(1'b1, `CSB_IDX_DATA, t, 2'b00);
      bus(1'b1, `CSB_IDX_CTRL1, 8'hA0, 2'b00);
      half(h);
      chk(h, 16, "half period");
      n = 0;
      while (pcnt < 8) begin
         @(negedge clk);
         n++;
         if (n > 3000) tmo();
      end
      chk(prx, t, "sent byte");
      bus(1'b0, `CSB_IDX_MODE, 8'h08, 2'b00);
      bus(1'b0, `CSB_IDX_IRQ_STAT, 8'h03, 2'b00);
      chk(irq, 1'b0, "irq masked");
      bus(1'b1, `CSB_IDX_IRQ_MASK, 8'h01, 2'b00);
      @(negedge clk);
      chk(irq, 1'b1, "irq raised");
      bus(1'b1, `CSB_IDX_IRQ_STAT, 8'h01, 2'b00);
      @(negedge clk);
      chk(irq, 1'b0, "irq cleared");
      bus(1'b0, `CSB_IDX_DATA, ptx, 2'b00);
      bus(1'b1, `CSB_IDX_CTRL1, 8'h20, 2'b00);
      bus(1'b0, `CSB_IDX_MODE, 8'h00, 2'b00);
      $display("test byte exchange done");
      for (int c = 1; c < 7; c++) begin
         seed = xs(seed);
         bus(1'b1, `CSB_IDX_CTRL1, {5'b01000, c[2:0]}, 2'b00);
         bus(1'b1, `CSB_IDX_DATA, seed[7:0], 2'b00);
         bus(1'b1, `CSB_IDX_CTRL1, {5'b10000, c[2:0]}, 2'b00);
         half(h);
         chk(h, 16 << c, "rate");
         bus(1'b1, `CSB_IDX_CTRL1, {5'b01000, c[2:0]}, 2'b00);
         bus(1'b0, `CSB_IDX_MODE, 8'h00, 2'b00);
      end
      $display("test rates and abort done");
      for (int m = 0; m < 4; m++) begin
         if (m != 1) begin
            bus(1'b1, `CSB_IDX_MODE, {4'h0, m[1:0], 2'b00}, 2'b00);
            bus(1'b1, `CSB_IDX_CTRL1, 8'h80, 2'b00);
            bus(1'b0, `CSB_IDX_MODE, 8'h00, 2'b00);
            chk(oen, 1'b1, "pin released");
            bus(1'b1, `CSB_IDX_CTRL1, 8'h40, 2'b00);
         end
      end
      bus(1'b1, `CSB_IDX_MODE, 8'h04, 2'b00);
      bus(1'b1, `CSB_IDX_CTRL1, 8'h50, 2'b00);
      bus(1'b1, `CSB_IDX_CTRL1, 8'h90, 2'b00);
      bus(1'b0, `CSB_IDX_MODE, 8'h00, 2'b00);
      bus(1'b1, `CSB_IDX_CTRL1, 8'h57, 2'b00);
      chk(oen, 1'b1, "external clock");
      bus(1'b1, `CSB_IDX_CTRL1, 8'h70, 2'b00);
      bus(1'b1, `CSB_IDX_CTRL1, 8'hB0, 2'b00);
      bus(1'b0, `CSB_IDX_MODE, 8'h0C, 2'b00);
      bus(1'b1, `CSB_IDX_CTRL1, 8'h70, 2'b00);
      seed = xs(seed);
      t = seed[7:0];
      bus(1'b1, `CSB_IDX_CTRL1, 8'h47, 2'b00);
      bus(1'b1, `CSB_IDX_DATA, t, 2'b00);
      bus(1'b1, `CSB_IDX_CTRL1, 8'h87, 2'b00);
      repeat (2) @(posedge clk);
      for (int b = 0; b < 8; b++) begin
         xck <= 1'b0;
         repeat (4) @(posedge clk);
         x = {so, x[7:1]};
         xck <= 1'b1;
         repeat (4) @(posedge clk);
      end
      chk(x, t, "external clock byte");
      bus(1'b0, `CSB_IDX_MODE, 8'h08, 2'b00);
      bus(1'b1, `CSB_IDX_CTRL1, 8'h47, 2'b00);
      $display("test modes done");
      print_verdict();
   end
endmodule
`default_nettype wire
